// ---- adc_ctl_pkg.sv ----
package adc_ctl_pkg;
   // Register word indices (printed offsets not all multiples of four,
   // so each is an index and the byte address is four times it)
   localparam logic [11:0] IDX_CONTROL = 12'h858;
   localparam logic [11:0] IDX_RESULT_HIGH = 12'h859;
   localparam logic [11:0] IDX_AVG_LOW = 12'h85A;
   localparam logic [11:0] IDX_RAW_LOW = 12'h85B;
   localparam logic [11:0] IDX_FINE_TRIM = 12'h85E;
   localparam logic [11:0] IDX_IRQ_ROUTE = 12'h864;
   localparam logic [11:0] IDX_IRQ_STATUS = 12'h870;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h871;
   localparam int ADDR_W = 14;
   // Control fields
   localparam int CTL_ENABLE = 0;
   localparam int CTL_AVG_LSB = 1;
   localparam int CTL_MODE = 4;
   localparam int CTL_CLK_LSB = 5;
   localparam logic [7:0] CTL_READ_MASK = 8'h1F;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int ROUTE_BIT = 3;
   localparam int TRIM_W = 6;
   localparam int RES_W = 12;
   localparam int AVG_MAX_LOG = 7;
   // Clock rates
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int CONV_4MHZ_HZ = 4_000_000;
   localparam int DIV_4MHZ = SYS_CLK_HZ / CONV_4MHZ_HZ;
   localparam int DIV_W = 8;
   typedef enum logic [1:0]
   {
      CLK_4MHZ = 2'b00,
      CLK_2MHZ = 2'b01,
      CLK_1MHZ = 2'b10,
      CLK_500KHZ = 2'b11
   } conv_clock_t;
   typedef struct packed
   {
      logic [1:0] clock_select;
      logic mode;
      logic [2:0] depth;
      logic enable;
   } control_t;
   typedef struct packed
   {
      logic [RES_W-1:0] averaged;
      logic [RES_W-1:0] raw;
   } result_t;
endpackage : adc_ctl_pkg

// ---- conv_clock_div.sv ----
`timescale 1ns/1ns
`default_nettype none
module conv_clock_div
   import adc_ctl_pkg::*;
#(
   parameter int BASE_DIV = DIV_4MHZ
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [1:0] select_i,
   output logic tick_o
);
   logic [DIV_W-1:0] count;
   logic [DIV_W-1:0] limit;

   // Slower rates are multiples of the 4 MHz period
   always_comb
   begin
      limit = DIV_W'(BASE_DIV - 1);
      case (conv_clock_t'(select_i))
         CLK_4MHZ: limit = DIV_W'(BASE_DIV - 1);
         CLK_2MHZ: limit = DIV_W'(BASE_DIV * 2 - 1);
         CLK_1MHZ: limit = DIV_W'(BASE_DIV * 4 - 1);
         CLK_500KHZ: limit = DIV_W'(BASE_DIV * 8 - 1);
         default: limit = DIV_W'(BASE_DIV - 1);
      endcase
   end

   // Counter restarts when idle so the first tick has full spacing
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !run_i)
      begin
         count <= '0;
         tick_o <= 1'b0;
      end
      else if (count >= limit)
      begin
         count <= '0;
         tick_o <= 1'b1; // R4
      end
      else
      begin
         count <= count + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule : conv_clock_div
`default_nettype wire

// ---- moving_average.sv ----
`timescale 1ns/1ns
`default_nettype none
module moving_average
   import adc_ctl_pkg::*;
#(
   parameter int MAX_LOG = AVG_MAX_LOG
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic sample_i,
   input wire logic [RES_W-1:0] data_i,
   input wire logic [2:0] depth_i,
   output logic [RES_W-1:0] average_o
);
   localparam int DEPTH = 1 << MAX_LOG;
   localparam int SUM_W = RES_W + MAX_LOG;
   logic [RES_W-1:0] window [DEPTH];
   logic [MAX_LOG-1:0] wr_ptr;
   logic [MAX_LOG:0] fill;
   logic [SUM_W-1:0] sum;

   // Index of the sample that leaves a window of given depth
   function automatic logic [MAX_LOG-1:0] oldest(
      input logic [MAX_LOG-1:0] ptr, input logic [2:0] lg);
      oldest = ptr - MAX_LOG'((1 << lg) % DEPTH);
   endfunction : oldest

   // Running sum over the last 2^depth samples; until the window
   // fills, the sum is over fewer samples and reads low
   always_ff @(posedge clk_i)
   begin
      if (rst_i || clear_i)
      begin
         wr_ptr <= '0;
         fill <= '0;
         sum <= '0;
         average_o <= '0;
      end
      else if (sample_i)
      begin
         window[wr_ptr] <= data_i;
         wr_ptr <= wr_ptr + 1'b1;
         if (depth_i == 3'b000)
         begin
            sum <= '0;
            average_o <= data_i; // R2
         end
         else if (fill >= (MAX_LOG+1)'(1 << depth_i))
         begin
            sum <= sum + SUM_W'(data_i)
               - SUM_W'(window[oldest(wr_ptr, depth_i)]); // R2
            average_o <= RES_W'((sum + SUM_W'(data_i)
               - SUM_W'(window[oldest(wr_ptr, depth_i)])) >> depth_i);
         end
         else
         begin
            fill <= fill + 1'b1;
            sum <= sum + SUM_W'(data_i);
            average_o <= RES_W'((sum + SUM_W'(data_i)) >> depth_i);
         end
      end
   end
endmodule : moving_average
`default_nettype wire

// ---- adc_control_and_averaging.sv ----
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1: Writing enable starts conversion; single mode clears enable when done.
// R2: Three-bit selector picks averaging depth: off, or 2 to 128 samples.
// R3: Mode bit zero is single, one is continuous with no auto clear.
// R4: Clock select picks 4, 2, 1 MHz or 500 KHz conversion clock.
// R5: Result bytes: high nibbles, averaged low byte, raw low byte, read only.
// R6: Six-bit write-only fine-trim value drives the analog converter.
// R7: Write-only routing bit gates the converter interrupt to the processor.
// R8: Continuous mode converts and raises an interrupt at every result.
module adc_control_and_averaging
   import adc_ctl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic conv_start_o,
   output logic conv_sample_o,
   input wire logic conv_done_i,
   input wire logic [RES_W-1:0] conv_data_i,
   output logic [1:0] conv_clock_select_o,
   output logic [TRIM_W-1:0] reference_fine_trim_o,
   output logic irq_o
);
   control_t control;
   result_t result;
   logic [TRIM_W-1:0] reference_fine_trim;
   logic converter_irq_route_enable;
   logic irq_status;
   logic irq_mask;
   logic busy;
   logic tick;
   logic done_meta;
   logic done_sync;
   logic done_prev;
   logic done_pulse;
   logic [RES_W-1:0] data_meta;
   logic [RES_W-1:0] data_sync;
   logic [RES_W-1:0] averaged;
   logic bus_req;
   logic bus_write;
   logic [11:0] index;
   logic write_control;
   logic next_enable;

   // Word index from the byte address
   assign index = wb_adr_i[ADDR_W-1:2];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_write = bus_req && wb_we_i && wb_sel_i[0];
   assign write_control = bus_write && (index == IDX_CONTROL);

   // One wait state answer: ack one cycle after the request is seen
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= bus_req;
   end

   // Read mux; write-only and unmapped words read zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= '0;
      else if (bus_req && !wb_we_i)
      begin
         wb_dat_o <= '0;
         case (index)
            IDX_CONTROL: wb_dat_o[7:0] <= control & CTL_READ_MASK;
            IDX_RESULT_HIGH: wb_dat_o[7:0] <=
               {averaged[11:8], result.raw[11:8]}; // R5
            IDX_AVG_LOW: wb_dat_o[7:0] <= averaged[7:0]; // R5
            IDX_RAW_LOW: wb_dat_o[7:0] <= result.raw[7:0]; // R5
            IDX_IRQ_STATUS: wb_dat_o[0] <= irq_status;
            IDX_IRQ_MASK: wb_dat_o[0] <= irq_mask;
            default: wb_dat_o <= '0;
         endcase
      end
   end

   // Converter done and data cross from the analog macro
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         done_meta <= 1'b0;
         done_sync <= 1'b0;
         done_prev <= 1'b0;
         data_meta <= '0;
         data_sync <= '0;
      end
      else
      begin
         done_meta <= conv_done_i;
         done_sync <= done_meta;
         done_prev <= done_sync;
         data_meta <= conv_data_i;
         data_sync <= data_meta;
      end
   end
   assign done_pulse = done_sync && !done_prev;

   // Enable: a write wins over the auto clear so software intent holds
   always_comb
   begin
      next_enable = control.enable;
      if (done_pulse && busy && !control.mode)
         next_enable = 1'b0; // R1 R3
      if (write_control)
         next_enable = wb_dat_i[CTL_ENABLE]; // R1
   end

   // Control register fields
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         control <= control_t'(RESET_BYTE[6:0]);
      else
      begin
         control.enable <= next_enable;
         if (write_control)
         begin
            control.depth <= wb_dat_i[CTL_AVG_LSB +: 3]; // R2
            control.mode <= wb_dat_i[CTL_MODE]; // R3
            control.clock_select <= wb_dat_i[CTL_CLK_LSB +: 2]; // R4
         end
      end
   end

   // Trim and routing are write only
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         reference_fine_trim <= RESET_BYTE[TRIM_W-1:0];
         converter_irq_route_enable <= 1'b0;
      end
      else if (bus_write)
      begin
         if (index == IDX_FINE_TRIM)
            reference_fine_trim <= wb_dat_i[TRIM_W-1:0]; // R6
         if (index == IDX_IRQ_ROUTE)
            converter_irq_route_enable <= wb_dat_i[ROUTE_BIT]; // R7
      end
   end
   assign reference_fine_trim_o = reference_fine_trim; // R6
   assign conv_clock_select_o = control.clock_select;

   // Conversion sequencing: one start per result in flight
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy <= 1'b0;
         conv_start_o <= 1'b0;
      end
      else
      begin
         conv_start_o <= 1'b0;
         if (busy && done_pulse)
            busy <= 1'b0;
         else if (!busy && control.enable && !write_control)
         begin
            busy <= 1'b1;
            conv_start_o <= 1'b1; // R1 R8
         end
      end
   end

   // Raw result captured on completion
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         result.raw <= '0;
      else if (busy && done_pulse)
         result.raw <= data_sync; // R8
   end
   assign result.averaged = averaged;

   // Interrupt status: sticky, set wins over write-one clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_status <= 1'b0;
         irq_mask <= 1'b0;
      end
      else
      begin
         if (bus_write && index == IDX_IRQ_MASK)
            irq_mask <= wb_dat_i[0];
         if (busy && done_pulse)
            irq_status <= 1'b1; // R8
         else if (bus_write && index == IDX_IRQ_STATUS && wb_dat_i[0])
            irq_status <= 1'b0;
      end
   end
   assign irq_o = irq_status && irq_mask && converter_irq_route_enable; // R7

   // Sample clock for the analog macro, running while busy
   conv_clock_div u_div
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(busy),
      .select_i(control.clock_select),
      .tick_o(tick)
   );
   assign conv_sample_o = tick; // R4

   // Averager restarts when depth changes via control write
   moving_average u_avg
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(write_control && (wb_dat_i[CTL_AVG_LSB +: 3] != control.depth)),
      .sample_i(busy && done_pulse),
      .data_i(data_sync),
      .depth_i(control.depth),
      .average_o(averaged)
   );
endmodule : adc_control_and_averaging
`default_nettype wire

// ---- adc_ctl_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_ctl_checker
   import adc_ctl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic conv_start_o,
   input wire logic [1:0] conv_clock_select_o,
   input wire logic [TRIM_W-1:0] reference_fine_trim_o,
   input wire logic irq_o
);
   logic req;
   logic wr;
   logic ctl_a;
   logic trim_a;
   logic route_a;
   // A write lands only at its own ack edge
   assign req = wb_cyc_i && wb_stb_i;
   assign wr = req && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign ctl_a = wb_adr_i == {IDX_CONTROL, 2'b00};
   assign trim_a = wb_adr_i == {IDX_FINE_TRIM, 2'b00};
   assign route_a = wb_adr_i == {IDX_IRQ_ROUTE, 2'b00};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   AST_START: assert property (
      wr && ctl_a && wb_dat_i[0] |-> ##[1:3] conv_start_o)
      else $error("no start");
   AST_START_ONE: assert property (conv_start_o |=> !conv_start_o)
      else $error("start too long");
   AST_CLK_SEL: assert property (
      wr && ctl_a |=> conv_clock_select_o == $past(wb_dat_i[6:5]))
      else $error("clock select wrong");
   AST_TRIM: assert property (
      wr && trim_a |=> reference_fine_trim_o == $past(wb_dat_i[5:0]))
      else $error("trim wrong");
   AST_ROUTE_OFF: assert property (
      wr && route_a && !wb_dat_i[3] |-> ##2 !irq_o)
      else $error("irq not gated");
   AST_CTL_READ: assert property (
      req && !wb_we_i && wb_ack_o && ctl_a |-> wb_dat_o[7:5] == 3'h0)
      else $error("control read unmasked");
endmodule : adc_ctl_checker
`default_nettype wire

// ---- adc_macro_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_macro_model
   import adc_ctl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic sample_i,
   input wire logic [RES_W-1:0] value_i,
   output logic done_o,
   output logic [RES_W-1:0] data_o
);
   logic busy;
   logic [3:0] cnt;
   // Fourteen ticks a result; data churns unless done holds it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy <= 1'b0;
         cnt <= 4'h0;
         done_o <= 1'b0;
         data_o <= 12'hFFF;
      end
      else if (start_i)
      begin
         busy <= 1'b1;
         cnt <= 4'h0;
         done_o <= 1'b0;
         data_o <= ~data_o;
      end
      else if (sample_i)
      begin
         cnt <= cnt + 4'h1;
         busy <= busy && cnt != 4'hD;
         done_o <= busy && cnt == 4'hD;
         data_o <= busy && cnt == 4'hD ? value_i : ~data_o;
      end
   end
endmodule : adc_macro_model
`default_nettype wire

// ---- adc_control_and_averaging_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_control_and_averaging_tb
   import adc_ctl_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [ADDR_W-1:0] adr = 14'h0000;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic ack, start, sample, done, irq;
   logic [RES_W-1:0] cdata;
   logic [RES_W-1:0] value = 12'h000;
   logic [1:0] csel;
   logic [TRIM_W-1:0] trim;
   int err_count = 0;
   int compares = 0;
   // 100 MHz clock
   always #5 clk_i = ~clk_i;
   adc_control_and_averaging adc_control_and_averaging_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .conv_start_o(start),
      .conv_sample_o(sample), .conv_done_i(done), .conv_data_i(cdata),
      .conv_clock_select_o(csel), .reference_fine_trim_o(trim),
      .irq_o(irq));
   adc_macro_model adc_macro_model_inst (
      .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .sample_i(sample),
      .value_i(value), .done_o(done), .data_o(cdata));
   task results;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   task chk(input string n, input logic [31:0] got, input logic [31:0] e);
      compares++;
      if (got !== e)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, got);
      end
   endtask : chk
   // One classic cycle; the wait for ack is bounded
   task wb(input logic w, input logic [11:0] i, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h000000, d};
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("ack", 32'(ack), 32'h1);
      if (ack !== 1'b1)
         results();
   endtask : wb
   task wr(input logic [11:0] i, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, i, d, q);
   endtask : wr
   task rd(input string n, input logic [11:0] i, input logic [7:0] e);
      logic [7:0] q;
      wb(1'b0, i, 8'h00, q);
      chk(n, 32'(q), 32'(e));
   endtask : rd
   task irq_is(input string n, input logic e);
      repeat (2) @(posedge clk_i);
      chk(n, 32'(irq), 32'(e));
   endtask : irq_is
   task wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 4000)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("irq", 32'(irq), 32'h1);
      if (irq !== 1'b1)
         results();
      wr(IDX_IRQ_STATUS, 8'h01);
   endtask : wait_irq
   // Start one conversion, time its ticks, read back control and the three result bytes
   task conv(input logic [7:0] c, input logic [11:0] v,
      input logic [11:0] a);
      int n;
      value <= v;
      wr(IDX_CONTROL, c);
      irq_is("irq idle", 1'b0);
      chk("clock select", 32'(csel), 32'(c[6:5]));
      for (int k = 0; k < 2; k++)
      begin
         n = 0;
         do
         begin
            @(posedge clk_i);
            n++;
         end
         while (sample !== 1'b1 && n < 1000);
      end
      chk("tick period", 32'(n), 32'(DIV_4MHZ << c[6:5]));
      wait_irq();
      rd("control", IDX_CONTROL, c & 8'h1E);
      rd("high", IDX_RESULT_HIGH, {a[11:8], v[11:8]});
      rd("avg low", IDX_AVG_LOW, a[7:0]);
      rd("raw low", IDX_RAW_LOW, v[7:0]);
   endtask : conv
   task t_reset;
      logic [11:0] idx [9] = '{IDX_CONTROL, IDX_RESULT_HIGH, IDX_AVG_LOW,
         IDX_RAW_LOW, IDX_FINE_TRIM, IDX_IRQ_ROUTE, IDX_IRQ_STATUS,
         IDX_IRQ_MASK, 12'h85C};
      foreach (idx[i])
         rd("reset value", idx[i], 8'h00);
      $display("test reset done");
   endtask : t_reset
   task t_irq;
      int n;
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_FINE_TRIM, 8'hEA);
      repeat (2) @(posedge clk_i);
      chk("trim", 32'(trim), 32'h2A);
      rd("trim read", IDX_FINE_TRIM, 8'h00);
      value <= 12'h6B7;
      wr(IDX_CONTROL, 8'h01);
      n = 0;
      while (done !== 1'b1 && n < 1000)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("done seen", 32'(done), 32'h1);
      irq_is("irq route off", 1'b0);
      rd("status", IDX_IRQ_STATUS, 8'h01);
      wr(IDX_RAW_LOW, 8'hFF);
      rd("raw read only", IDX_RAW_LOW, 8'hB7);
      wr(IDX_IRQ_ROUTE, 8'h08);
      irq_is("irq route on", 1'b1);
      wr(IDX_IRQ_ROUTE, 8'h00);
      irq_is("irq route gated", 1'b0);
      wr(IDX_IRQ_ROUTE, 8'h08);
      irq_is("irq route again", 1'b1);
      wr(IDX_IRQ_MASK, 8'h00);
      irq_is("irq masked", 1'b0);
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_IRQ_STATUS, 8'h01);
      irq_is("irq cleared", 1'b0);
      $display("test irq done");
   endtask : t_irq
   task t_depth;
      for (int d = 1; d < 8; d++)
         conv({4'h0, 3'(d), 1'b1}, 12'h800, 12'h800 >> d);
      for (int k = 0; k < 3; k++)
         conv(8'h03, 12'(12'h200 * (k + 1)), 12'(12'h200 * k + 12'h100));
      for (int c = 0; c < 4; c++)
         conv({1'b0, 2'(c), 5'h01}, 12'h9C3, 12'h9C3);
      $display("test depth and clock done");
   endtask : t_depth
   task t_cont;
      value <= 12'h321;
      wr(IDX_CONTROL, 8'h11);
      wait_irq();
      wait_irq();
      rd("control", IDX_CONTROL, 8'h11);
      rd("raw low", IDX_RAW_LOW, 8'h21);
      wr(IDX_CONTROL, 8'h10);
      rd("control stop", IDX_CONTROL, 8'h10);
      $display("test continuous done");
   endtask : t_cont
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_irq();
      t_depth();
      t_cont();
      results();
   end
endmodule : adc_control_and_averaging_tb
bind adc_control_and_averaging adc_ctl_checker adc_ctl_checker_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .conv_start_o(conv_start_o), .conv_clock_select_o(conv_clock_select_o),
   .reference_fine_trim_o(reference_fine_trim_o), .irq_o(irq_o));
`default_nettype wire
